// File: design/elastic_buffer.sv
// small fifo that absorbs rate and phase drift between line and launch clock
`timescale 1ns/100ps
`default_nettype none
module elastic_buffer #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_edge,
  input  wire logic [1:0]       prefill,
  output logic                  rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  empty,
  output logic                  overflow
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      level_q;
  logic             run_q;
  logic             do_wr;

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("elastic_buffer: depth must be a power of two >= 4");
  end

  assign empty    = (level_q == '0);
  assign overflow = wr_en && (level_q == (AW+1)'(DEPTH)) && !rd_en;
  assign do_wr    = wr_en && !overflow;
  // reading starts once the fill reaches the setting plus one, then follows each edge
  assign rd_en    = rd_edge && !empty && (run_q || level_q > {{(AW-1){1'b0}}, prefill});
  assign rd_data  = mem_q[rd_ptr_q];

  // storage and pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
    end else begin
      if (do_wr) begin
        mem_q[wr_ptr_q] <= wr_data;
        wr_ptr_q        <= wr_ptr_q + 1'b1;
      end
      if (rd_en) rd_ptr_q <= rd_ptr_q + 1'b1;
      level_q <= level_q + (AW+1)'(do_wr) - (AW+1)'(rd_en);
    end
  end

  // a frame keeps draining until the buffer runs dry with no new write
  always_ff @(posedge clk) begin
    if (rst) run_q <= 1'b0;
    else if (rd_en) run_q <= 1'b1;
    else if (empty && !wr_en) run_q <= 1'b0;
  end
endmodule : elastic_buffer
`default_nettype wire

// File: design/rmii_timing.sv
// reduced-mii mac-side transmit and receive timing of a 10/100 transceiver
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] mac holds txd and tx_en stable for capture at reference rising edge
// [R2] receive outputs launch from reference rising edge, 20 ns period
// [R3] transmit line output follows capture by 12 bit times
// [R4] crs_dv asserts without waiting for an edge, 17.6 bits after start
// [R5] crs_dv drops on a launch edge, 26.2 bits after end of stream
// [R6] rx_dv is provided, synchronous to the reference clock
// [R7] receive data latency 29.7 bits with elasticity setting 01
// [R8] recovered receive clock mode only when control bit 0 is set
// [R9] in that mode rx_clk is driven at 50 MHz from received timing
// [R10] in that mode receive outputs launch from rx_clk rising edge
// [R11] after entering loopback no receive data for up to 550 us
// [R12] loopback delay 9, 121 or 233 ns for mii, pcs and analog
// [R13] external loopback delay 242 ns, or 202 ns in fast mode
// [R14] elasticity buffer absorbs drift without losing or doubling dibits
module rmii_timing
  import rmii_timing_pkg::*;
#(
  parameter int DEAD_CYCLES = DEAD_CYC,
  parameter int EB_DEPTH    = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // mac side
  input  wire logic        reference_clock_input,
  input  wire logic [1:0]  txd,
  input  wire logic        tx_en,
  output logic      [1:0]  rxd,
  output logic             crs_dv,
  output logic             rx_dv,
  output logic             rx_er,
  output logic             rx_clk,
  // line side, one dibit per strobe
  output logic      [1:0]  line_tx_dibit,
  output logic             line_tx_en,
  input  wire logic        line_rx_valid,
  input  wire logic [1:0]  line_rx_dibit,
  input  wire logic        line_rx_err,
  input  wire logic        line_rx_sos,
  input  wire logic        line_rx_eos
);
  localparam int LB_DEPTH = LB_EXT_CYC;

  if (DEAD_CYCLES < 1) begin : g_bad_dead
    $error("rmii_timing: dead time must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0]  rxclk_ctrl_q;
  loop_mode_t   loop_mode_q;
  logic         rxclk_mode;
  logic [1:0]   elast_set;
  logic [15:0]  status;
  logic         dead_active;
  logic         eb_empty;
  logic         eb_overflow;
  logic         eb_ovf_q;

  assign rxclk_mode = rxclk_ctrl_q[RXCLK_EN_BIT];
  assign elast_set  = rxclk_ctrl_q[ELAST_LSB +: 2];

  // control writes
  always_ff @(posedge clk) begin
    if (rst) begin
      rxclk_ctrl_q <= RXCLK_RESET;
      loop_mode_q  <= LOOP_NONE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_RXCLK_CTRL) rxclk_ctrl_q <= reg_wdata; // R8
      if (reg_addr == ADDR_LOOP_CTRL) loop_mode_q <= loop_mode_t'(reg_wdata[2:0]);
    end
  end

  // overflow stays seen until the status register is read; a new one wins
  always_ff @(posedge clk) begin
    if (rst) eb_ovf_q <= 1'b0;
    else if (eb_overflow) eb_ovf_q <= 1'b1;
    else if (reg_rd && reg_addr == ADDR_STATUS) eb_ovf_q <= 1'b0;
  end

  assign status = {12'h000, eb_ovf_q, eb_empty, dead_active, crs_dv};

  // read data stands the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_RXCLK_CTRL: reg_rdata <= rxclk_ctrl_q;
        ADDR_LOOP_CTRL:  reg_rdata <= {13'h0000, loop_mode_q};
        ADDR_STATUS:     reg_rdata <= status;
        default:         reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock edges

  logic       ref_q;
  logic       ref_rise;
  logic [2:0] div_q;
  logic       rec_rise;
  logic       launch;
  logic       line_valid_q;

  assign ref_rise = reference_clock_input && !ref_q;
  assign rec_rise = (div_q == 3'h0);
  assign launch   = rxclk_mode ? rec_rise : ref_rise; // R2 R10

  // reference clock level for edge detection
  always_ff @(posedge clk) begin
    if (rst) ref_q <= 1'b0;
    else ref_q <= reference_clock_input;
  end

  // recovered clock divider, realigned to each received dibit strobe (rising line_rx_valid)
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q        <= 3'h0;
      line_valid_q <= 1'b0;
    end else begin
      line_valid_q <= line_rx_valid;
      if (line_rx_valid && !line_valid_q) div_q <= 3'h1; // R9
      else if (div_q == 3'(CLK_PER_REF - 1)) div_q <= 3'h0;
      else div_q <= div_q + 3'h1;
    end
  end

  // rx_clk high for the first part of each period; mode is looked at only at a
  // period start, so turning it on or off never leaves a runt high phase
  always_ff @(posedge clk) begin
    if (rst) rx_clk <= 1'b0;
    else if (div_q == 3'h0) rx_clk <= rxclk_mode; // R9
    else rx_clk <= rx_clk && (div_q < 3'(CLK_PER_REF / 2)); // R9
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path

  logic [1:0] txd_cap_q;
  logic       tx_en_cap_q;
  logic [2:0] tx_line;
  logic       line_blocked;

  // mac inputs captured only at the reference rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      txd_cap_q   <= 2'h0;
      tx_en_cap_q <= 1'b0;
    end else if (ref_rise) begin
      txd_cap_q   <= txd;   // R1
      tx_en_cap_q <= tx_en; // R1
    end
  end

  tap_delay #(.WIDTH(3), .DEPTH(TX_LAT_CYC)) u_tx_delay (
    .clk  (clk),
    .rst  (rst),
    .din  ({tx_en_cap_q, txd_cap_q}),
    .tap  ($clog2(TX_LAT_CYC+1)'(TX_LAT_CYC)),
    .dout (tx_line)
  );

  // internal loopbacks keep the line quiet; external loopback still drives it
  assign line_blocked = (loop_mode_q == LOOP_MII) || (loop_mode_q == LOOP_PCS)
                        || (loop_mode_q == LOOP_ANALOG);

  always_ff @(posedge clk) begin
    if (rst) begin
      line_tx_en    <= 1'b0;
      line_tx_dibit <= 2'h0;
    end else begin
      line_tx_en    <= tx_line[2] && !line_blocked;            // R3
      line_tx_dibit <= line_blocked ? 2'h0 : tx_line[1:0];     // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loopback path

  logic [$clog2(LB_DEPTH+1)-1:0] lb_tap;
  logic [2:0]                    lb_out;
  logic [$clog2(DEAD_CYCLES+1)-1:0] dead_q;
  loop_mode_t                    loop_prev_q;

  // delay chosen by loopback kind
  always_comb begin
    case (loop_mode_q)
      LOOP_MII:      lb_tap = $bits(lb_tap)'(LB_MII_CYC);  // R12
      LOOP_PCS:      lb_tap = $bits(lb_tap)'(LB_PCS_CYC);  // R12
      LOOP_ANALOG:   lb_tap = $bits(lb_tap)'(LB_ANA_CYC);  // R12
      LOOP_EXT:      lb_tap = $bits(lb_tap)'(LB_EXT_CYC);  // R13
      LOOP_EXT_FAST: lb_tap = $bits(lb_tap)'(LB_EXTF_CYC); // R13
      default:       lb_tap = $bits(lb_tap)'(1);
    endcase
  end

  tap_delay #(.WIDTH(3), .DEPTH(LB_DEPTH)) u_lb_delay (
    .clk  (clk),
    .rst  (rst),
    .din  ({tx_en_cap_q, txd_cap_q}),
    .tap  (lb_tap),
    .dout (lb_out)
  );

  // dead time restarts whenever a loopback mode is entered or changed
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_prev_q <= LOOP_NONE;
      dead_q      <= '0;
    end else begin
      loop_prev_q <= loop_mode_q;
      if (loop_mode_q != loop_prev_q && loop_mode_q != LOOP_NONE)
        dead_q <= $bits(dead_q)'(DEAD_CYCLES); // R11
      else if (dead_q != '0)
        dead_q <= dead_q - 1'b1;
    end
  end

  assign dead_active = (dead_q != '0);

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  logic [3:0] rx_late;
  logic       sos_late;
  logic       eos_late;
  logic       eb_rd;
  logic [2:0] eb_data;
  logic       crs_off_pend_q;
  logic       looping;

  assign looping = (loop_mode_q != LOOP_NONE);

  tap_delay #(.WIDTH(4), .DEPTH(RX_LAT_CYC - CLK_PER_REF)) u_rx_delay (
    .clk  (clk),
    .rst  (rst),
    .din  ({line_rx_valid, line_rx_err, line_rx_dibit}),
    .tap  ($clog2(RX_LAT_CYC-CLK_PER_REF+1)'(RX_LAT_CYC - CLK_PER_REF)),
    .dout (rx_late)
  );

  tap_delay #(.WIDTH(1), .DEPTH(CRS_ON_CYC)) u_sos_delay (
    .clk  (clk),
    .rst  (rst),
    .din  (line_rx_valid && line_rx_sos),
    .tap  ($clog2(CRS_ON_CYC+1)'(CRS_ON_CYC)),
    .dout (sos_late)
  );

  tap_delay #(.WIDTH(1), .DEPTH(CRS_OFF_CYC)) u_eos_delay (
    .clk  (clk),
    .rst  (rst),
    .din  (line_rx_valid && line_rx_eos),
    .tap  ($clog2(CRS_OFF_CYC+1)'(CRS_OFF_CYC)),
    .dout (eos_late)
  );

  // line dibits cross into the launch timing through the elasticity buffer
  elastic_buffer #(.WIDTH(3), .DEPTH(EB_DEPTH)) u_eb (
    .clk      (clk),
    .rst      (rst),
    .wr_en    (rx_late[3] && !looping),
    .wr_data  (rx_late[2:0]),
    .rd_edge  (launch),
    .prefill  (elast_set),
    .rd_en    (eb_rd),
    .rd_data  (eb_data),
    .empty    (eb_empty),
    .overflow (eb_overflow)
  ); // R14 R7

  // receive data and valid launched on the selected edge
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd   <= 2'h0;
      rx_er <= 1'b0;
      rx_dv <= 1'b0;
    end else if (launch) begin
      if (looping) begin
        rxd   <= dead_active ? 2'h0 : lb_out[1:0]; // R11
        rx_er <= 1'b0;
        rx_dv <= lb_out[2] && !dead_active;        // R11 R12 R13
      end else begin
        rxd   <= eb_rd ? eb_data[1:0] : 2'h0;      // R7
        rx_er <= eb_rd && eb_data[2];              // R7
        rx_dv <= eb_rd;                            // R6
      end
    end
  end

  // carrier off waits for a launch edge once the end of stream is due
  always_ff @(posedge clk) begin
    if (rst) crs_off_pend_q <= 1'b0;
    else if (eos_late) crs_off_pend_q <= 1'b1;
    else if (launch || sos_late) crs_off_pend_q <= 1'b0;
  end

  // crs_dv rises on the cycle the start is due, falls only on a launch edge
  always_ff @(posedge clk) begin
    if (rst) begin
      crs_dv <= 1'b0;
    end else if (looping) begin
      if (launch) crs_dv <= lb_out[2] && !dead_active;
    end else if (sos_late) begin
      crs_dv <= 1'b1;                               // R4
    end else if (crs_off_pend_q && launch) begin
      crs_dv <= 1'b0;                               // R5
    end
  end
endmodule : rmii_timing
`default_nettype wire

// File: design/rmii_timing_pkg.sv
// constants and register map of the reduced-mii data path timing block
package rmii_timing_pkg;
  // clock and line timing
  localparam int CLK_NS        = 4;     // core clock period
  localparam int REF_NS        = 20;    // reference and recovered clock period
  localparam int BIT_NS        = 10;    // one bit time at 100 mb/s
  localparam int CLK_PER_REF   = REF_NS / CLK_NS;
  // latencies in tenths of a bit time, as nominal figures
  localparam int TX_LAT_TBIT   = 120;
  localparam int CRS_ON_TBIT   = 176;
  localparam int CRS_OFF_TBIT  = 262;
  localparam int RX_LAT_TBIT   = 297;
  localparam int TX_LAT_CYC    = TX_LAT_TBIT * BIT_NS / (10 * CLK_NS);
  localparam int CRS_ON_CYC    = CRS_ON_TBIT * BIT_NS / (10 * CLK_NS);
  localparam int CRS_OFF_CYC   = CRS_OFF_TBIT * BIT_NS / (10 * CLK_NS);
  localparam int RX_LAT_CYC    = RX_LAT_TBIT * BIT_NS / (10 * CLK_NS);
  // loopback delays in ns and cycles
  localparam int LB_MII_NS     = 9;
  localparam int LB_PCS_NS     = 121;
  localparam int LB_ANA_NS     = 233;
  localparam int LB_EXT_NS     = 242;
  localparam int LB_EXTF_NS    = 202;
  localparam int LB_MII_CYC    = LB_MII_NS / CLK_NS;
  localparam int LB_PCS_CYC    = LB_PCS_NS / CLK_NS;
  localparam int LB_ANA_CYC    = LB_ANA_NS / CLK_NS;
  localparam int LB_EXT_CYC    = LB_EXT_NS / CLK_NS;
  localparam int LB_EXTF_CYC   = LB_EXTF_NS / CLK_NS;
  localparam int DEAD_US       = 550;
  localparam int DEAD_CYC      = DEAD_US * 1000 / CLK_NS;
  // register map
  localparam logic [3:0]  ADDR_RXCLK_CTRL = 4'ha;
  localparam logic [3:0]  ADDR_LOOP_CTRL  = 4'hb;
  localparam logic [3:0]  ADDR_STATUS     = 4'hc;
  localparam int          RXCLK_EN_BIT    = 0;
  localparam int          ELAST_LSB       = 1;
  localparam logic [1:0]  ELAST_RESET     = 2'h1;
  localparam logic [15:0] RXCLK_RESET     = 16'h0002;
  // loopback selection
  typedef enum logic [2:0] {
    LOOP_NONE, LOOP_MII, LOOP_PCS, LOOP_ANALOG, LOOP_EXT, LOOP_EXT_FAST
  } loop_mode_t;
endpackage : rmii_timing_pkg

// File: design/tap_delay.sv
// shift-register delay line with a selectable output tap
`timescale 1ns/100ps
`default_nettype none
module tap_delay #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [WIDTH-1:0]         din,
  input  wire logic [$clog2(DEPTH+1)-1:0] tap,
  output logic      [WIDTH-1:0]         dout
);
  logic [WIDTH-1:0] stage_q [DEPTH];

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("tap_delay: depth and width must be at least one");
  end

  // every stage moves on each edge; reset empties the line
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) stage_q[i] <= '0;
    end else begin
      stage_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) stage_q[i] <= stage_q[i-1];
    end
  end

  // tap n gives the input n cycles late; taps out of range give the last stage
  always_comb begin
    dout = stage_q[DEPTH-1];
    for (int i = 1; i <= DEPTH; i++) begin
      if (int'(tap) == i) dout = stage_q[i-1];
    end
  end
endmodule : tap_delay
`default_nettype wire

// File: tb/rmii_mac_model.sv
// mac partner: reference clock, transmit driver and receive logger
`timescale 1ns/100ps
`default_nettype none
module rmii_mac_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_go,
  input  wire logic [1:0] tx_dat,
  input  wire logic [1:0] rxd,
  input  wire logic       rx_dv,
  output logic            ref_clk,
  output logic      [1:0] txd,
  output logic            tx_en,
  output logic      [4:0] rx_n
);
  logic [2:0] ph_q;
  logic [1:0] rx_log [0:31];

  // 50 MHz reference, five core cycles with two high
  always_ff @(posedge clk) begin
    ph_q    <= (rst || ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
    ref_clk <= !rst && (ph_q == 3'h4 || ph_q == 3'h0);
  end

  // transmit moves mid-period so it is stable across the rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_en <= 1'b0;
      txd   <= 2'h0;
    end else if (ph_q == 3'h2) begin
      tx_en <= tx_go;
      txd   <= tx_go ? tx_dat : ~txd;
    end
  end

  // receive dibits taken late in each period, once launched
  always_ff @(posedge clk) begin
    if (rst)
      rx_n <= 5'h0;
    else if (ph_q == 3'h4 && rx_dv) begin
      rx_log[rx_n] <= rxd;
      rx_n         <= rx_n + 5'h1;
    end
  end
endmodule : rmii_mac_model
`default_nettype wire

// File: tb/rmii_timing_asserts.sv
// port checker for the reduced-mii timing block
`timescale 1ns/100ps
`default_nettype none
module rmii_timing_asserts
  import rmii_timing_pkg::*;
#(
  parameter int DEAD_CYCLES = DEAD_CYC
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reference_clock_input,
  input wire logic [1:0]  txd,
  input wire logic        tx_en,
  input wire logic [1:0]  rxd,
  input wire logic        crs_dv,
  input wire logic        rx_dv,
  input wire logic        rx_er,
  input wire logic        rx_clk,
  input wire logic [1:0]  line_tx_dibit,
  input wire logic        line_tx_en,
  input wire logic        line_rx_valid,
  input wire logic [1:0]  line_rx_dibit,
  input wire logic        line_rx_err,
  input wire logic        line_rx_sos,
  input wire logic        line_rx_eos
);
  logic       ref_q;
  logic       rxc_q;
  logic [2:0] lh_q;
  logic [2:0] ctrl_q;
  logic [2:0] loop_q;
  int         dead_q;
  wire logic  ref_rise = reference_clock_input & ~ref_q;
  wire logic  launch   = ref_rise | (rx_clk & ~rxc_q);
  wire logic  near     = |{lh_q, launch};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // edge history: receive outputs may only move up to three cycles after a launch edge
  always_ff @(posedge clk) begin
    ref_q <= reference_clock_input;
    rxc_q <= rx_clk;
    lh_q  <= {lh_q[1:0], launch};
  end

  // shadow of control and loop registers, and the loopback dead-time count
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= RXCLK_RESET[2:0];
      loop_q <= 3'h0;
      dead_q <= 0;
    end else begin
      if (reg_wr && reg_addr == ADDR_RXCLK_CTRL)
        ctrl_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == ADDR_LOOP_CTRL)
        loop_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == ADDR_LOOP_CTRL && reg_wdata[2:0] != 3'h0
          && reg_wdata[2:0] != loop_q)
        dead_q <= DEAD_CYCLES;
      else if (dead_q != 0)
        dead_q <= dead_q - 1;
    end
  end

  ////////////////////////////////////////
  property p_ctrl_rd;
    reg_rd && reg_addr == ADDR_RXCLK_CTRL |=> reg_rdata[2:0] == ctrl_q;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback differs");
  property p_rxclk_off;
    (!ctrl_q[0]) [*3] |-> !rx_clk;
  endproperty
  a_rxclk_off: assert property (p_rxclk_off)
    else $error("rx_clk runs while mode is off");
  property p_rxclk_high;
    $rose(rx_clk) |-> rx_clk [*2] ##1 !rx_clk;
  endproperty
  a_rxclk_high: assert property (p_rxclk_high)
    else $error("rx_clk high phase wrong");
  property p_out_launch;
    $changed(rxd) || $changed(rx_dv) || $changed(rx_er) |-> near;
  endproperty
  a_out_launch: assert property (p_out_launch)
    else $error("receive output moved off a launch edge");
  property p_crs_fall;
    $fell(crs_dv) |-> near;
  endproperty
  a_crs_fall: assert property (p_crs_fall)
    else $error("carrier dropped off a launch edge");
  property p_crs_on;
    line_rx_valid && line_rx_sos && loop_q == 3'h0 && !crs_dv |-> ##44 !crs_dv ##1 crs_dv;
  endproperty
  a_crs_on: assert property (p_crs_on)
    else $error("carrier rise delay wrong");
  property p_tx_lat;
    ref_rise && tx_en && loop_q == 3'h0 |-> ##32 line_tx_en && line_tx_dibit == $past(txd, 32);
  endproperty
  a_tx_lat: assert property (p_tx_lat)
    else $error("transmit latency or dibit wrong");
  property p_tx_block;
    (loop_q inside {3'h1, 3'h2, 3'h3}) [*3] |-> !line_tx_en;
  endproperty
  a_tx_block: assert property (p_tx_block)
    else $error("line transmit active in internal loop");
  property p_dead;
    dead_q != 0 |-> !rx_dv && !crs_dv && rxd == 2'h0;
  endproperty
  a_dead: assert property (p_dead)
    else $error("receive data during loop dead time");
  property p_mii_lb;
    loop_q == 3'h1 && dead_q == 0 && ref_rise && tx_en && !rx_dv |-> ##[2:9] rx_dv;
  endproperty
  a_mii_lb: assert property (p_mii_lb)
    else $error("mii loop delay too long");

  // main scenarios reached
  c_rxclk: cover property ($rose(rx_clk));
  c_crs: cover property ($rose(crs_dv));
  c_loop: cover property (loop_q == 3'h5 && $rose(rx_dv));
endmodule : rmii_timing_asserts

bind rmii_timing rmii_timing_asserts #(.DEAD_CYCLES(DEAD_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_clock_input(reference_clock_input),
  .txd(txd), .tx_en(tx_en), .rxd(rxd), .crs_dv(crs_dv), .rx_dv(rx_dv), .rx_er(rx_er),
  .rx_clk(rx_clk), .line_tx_dibit(line_tx_dibit), .line_tx_en(line_tx_en),
  .line_rx_valid(line_rx_valid), .line_rx_dibit(line_rx_dibit), .line_rx_err(line_rx_err),
  .line_rx_sos(line_rx_sos), .line_rx_eos(line_rx_eos)
);
`default_nettype wire

// File: tb/test_rmii_timing.sv
// self-checking bench for the reduced-mii timing block
`timescale 1ns/100ps
`default_nettype none
module test_rmii_timing;
  import rmii_timing_pkg::*;
  localparam int DEAD = 20;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        tx_go     = 1'b0;
  logic [1:0]  tx_dat    = 2'h0;
  logic        lv        = 1'b0;
  logic [1:0]  ld        = 2'h0;
  logic        ls        = 1'b0;
  logic        le        = 1'b0;
  logic        lr        = 1'b0;
  logic [15:0] reg_rdata;
  logic        ref_clk, tx_en, crs_dv, rx_dv, rx_er, rx_clk, line_tx_en;
  logic [1:0]  txd, rxd, line_tx_dibit;
  logic [4:0]  rx_n;
  int          lb [1:5]  = '{LB_MII_CYC, LB_PCS_CYC, LB_ANA_CYC, LB_EXT_CYC, LB_EXTF_CYC};
  int          mismatches = 0;
  int          tests_run  = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;

  rmii_timing #(.DEAD_CYCLES(DEAD)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_clock_input(ref_clk), .txd(txd),
    .tx_en(tx_en), .rxd(rxd), .crs_dv(crs_dv), .rx_dv(rx_dv), .rx_er(rx_er), .rx_clk(rx_clk),
    .line_tx_dibit(line_tx_dibit), .line_tx_en(line_tx_en), .line_rx_valid(lv),
    .line_rx_dibit(ld), .line_rx_err(lr), .line_rx_sos(ls), .line_rx_eos(le)
  );

  rmii_mac_model mac (
    .clk(clk), .rst(rst), .tx_go(tx_go), .tx_dat(tx_dat), .rxd(rxd), .rx_dv(rx_dv),
    .ref_clk(ref_clk), .txd(txd), .tx_en(tx_en), .rx_n(rx_n)
  );

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // bounded wait for a level, returns the cycles spent
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_lvl

  // one line dibit every reference period; idle data is inverted
  task automatic line(input logic [1:0] d, input logic s, input logic e);
    @(posedge clk);
    lv <= 1'b1;
    ld <= d;
    ls <= s;
    le <= e;
    @(posedge clk);
    lv <= 1'b0;
    ld <= ~d;
    ls <= 1'b0;
    le <= 1'b0;
    cyc(3);
  endtask : line

  task automatic test_done;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////
  initial begin
    int n;
    int k;
    logic [1:0] pat [0:7];
    pat = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h1, 2'h2};
    cyc(12);
    rst <= 1'b0;
    // reset values and an unmapped address
    rd(ADDR_RXCLK_CTRL, RXCLK_RESET);
    rd(ADDR_LOOP_CTRL, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(ADDR_STATUS, 16'h0004);
    // recovered clock silent until enabled, then two high and three low
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (rx_clk !== 1'b0)
        n++;
    end
    chk(16'(n), 16'h0000);
    wr(ADDR_RXCLK_CTRL, 16'h0003);
    rd(ADDR_RXCLK_CTRL, 16'h0003);
    wait_lvl(rx_clk, 1'b1, n);
    wait_lvl(rx_clk, 1'b0, n);
    wait_lvl(rx_clk, 1'b1, n);
    chk(16'(n), 16'h0003);
    wait_lvl(rx_clk, 1'b0, n);
    chk(16'(n), 16'h0002);
    wr(ADDR_RXCLK_CTRL, RXCLK_RESET);
    // three dibits through the transmit path, in order
    for (int i = 1; i < 4; i++) begin
      tx_go  <= 1'b1;
      tx_dat <= 2'(i);
      cyc(5);
    end
    tx_go <= 1'b0;
    wait_lvl(line_tx_en, 1'b1, n);
    cyc(2);
    for (int i = 1; i < 4; i++) begin
      chk({14'h0, line_tx_dibit}, 16'(i));
      cyc(5);
    end
    chk({15'h0, line_tx_en}, 16'h0000);
    // one frame from the line, logged by the partner in arrival order
    line(2'h0, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++)
      line(pat[i], 1'b0, 1'b0);
    lr <= 1'b1;
    line(2'h0, 1'b0, 1'b1);
    lr <= 1'b0;
    // the marked last dibit shows rx_er for exactly one launch period
    n = 0;
    repeat (150) begin
      @(posedge clk);
      n += int'(rx_er);
    end
    chk(16'(n), 16'h0005);
    k = 0;
    while (k < 8 && mac.rx_log[k] !== 2'h1)
      k++;
    for (int i = 0; i < 8; i++)
      chk({14'h0, mac.rx_log[k + i]}, {14'h0, pat[i]});
    chk(16'(k), 16'h0001);
    chk({11'h0, rx_n}, 16'h000a);
    chk({15'h0, crs_dv}, 16'h0000);
    // every loop mode: dead time, then the looped transmit enable
    for (int m = 1; m < 6; m++) begin
      wr(ADDR_LOOP_CTRL, 16'(m));
      rd(ADDR_STATUS, 16'h0006);
      cyc(DEAD + 10);
      tx_go <= 1'b1;
      wait_lvl(rx_dv, 1'b1, n);
      chk(16'(n >= lb[m] && n <= lb[m] + 16), 16'h0001);
      tx_go <= 1'b0;
      cyc(100);
      wr(ADDR_LOOP_CTRL, 16'h0000);
      cyc(100);
    end
    chk({15'h0, rx_dv}, 16'h0000);
    test_done();
  end

  // watchdog against a hang
  initial begin
    #40000;
    mismatches++;
    test_done();
  end
endmodule : test_rmii_timing
`default_nettype wire
